// File: shared/mtc_pkg.sv
// Constants, register map and carrier types of the multicast TLP classifier.
// Assumes one classifier per switch partition ingress, APB register access.
//
// Notes on behaviour
// - Up to 64 groups, each with controls
// - Max group field resets to 32 groups
// - Multicast stays inside its entry partition
// - Sender need not belong to group
// - One register set serves whole partition
// - Multicast gets normal error checking treatment
// - Multicast off means nothing is multicast
// - Non-multicast packets use ordinary unicast routing
// - Only posted writes, address messages qualify
// - Multicast keeps posted ordering, nothing added
// - Regions contiguous from group zero, enabled only
// - Region size two to index position
// - Base is 64 bits from two registers
// - Masked address compared against base
// - Group ID from address; out of range routes as unicast
// - Only ACS source validation applies
// - Block-all bit blocks the group
// - Block-untranslated bit blocks untranslated packets
// - Blocked: drop, credits, AER, target abort
package mtc_pkg;

  localparam int          GROUP_MAX       = 64;
  localparam logic [7:0]  OFF_CAPABILITY  = 8'h00;
  localparam logic [7:0]  OFF_CONTROL     = 8'h04;
  localparam logic [7:0]  OFF_BASE_LOW    = 8'h08;
  localparam logic [7:0]  OFF_BASE_HIGH   = 8'h0C;
  localparam logic [7:0]  OFF_BLKALL_LOW  = 8'h10;
  localparam logic [7:0]  OFF_BLKALL_HIGH = 8'h14;
  localparam logic [7:0]  OFF_BLKUT_LOW   = 8'h18;
  localparam logic [7:0]  OFF_BLKUT_HIGH  = 8'h1C;
  localparam logic [7:0]  OFF_STATUS      = 8'h20;
  localparam logic [7:0]  OFF_PORT_CFG    = 8'h24;

  // Field positions
  localparam int          POS_MC_ON       = 15;
  localparam int          POS_STA_PRI     = 0;
  localparam int          POS_STA_SEC     = 1;
  localparam int          POS_UPSTREAM    = 0;
  localparam int          BASE_LOW_LSB    = 12;

  // Encoded group count minus one: 6'h1F advertises 32 groups
  localparam logic [5:0]  RST_MAX_GROUP   = 6'h1F;
  localparam logic [1:0]  AT_UNTRANSLATED = 2'h0;

  typedef struct packed {
    logic        valid;
    logic        postedWrite;
    logic        addrMessage;
    logic        headerError;
    logic        acsSourceFail;
    logic [1:0]  addrType;
    logic [3:0]  partition;
    logic [63:0] addr;
  } mtc_tlp_t;

  typedef struct packed {
    logic        valid;
    logic        multicast;
    logic        headerError;
    logic [5:0]  groupId;
    logic [3:0]  partition;
    logic [63:0] addr;
  } mtc_bus_t;

  typedef struct packed {
    logic        mcBlocked;
    logic        creditReturn;
    logic        acsViolation;
    logic [63:0] loggedAddr;
  } mtc_err_t;

  typedef struct packed {
    logic [5:0]  max_group_count;
    logic [5:0]  enabled_group_count;
    logic        mcOn;
    logic [31:0] baseLow;
    logic [31:0] baseHigh;
    logic [63:0] blockAll;
    logic [63:0] blockUt;
    logic        staPrimary;
    logic        staSecondary;
    logic        upstream;
    logic [31:0] prdata;
    logic        pslverr;
    mtc_bus_t    busOut;
    mtc_err_t    errOut;
  } mtc_state_t;

endpackage : mtc_pkg

// File: core/mtc_classifier.sv
// Ingress multicast classifier: decides multicast, checks blocks, feeds virtual bus.
// Assumes header fields arrive one packet per valid cycle, synchronous to clock.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps

module mtc_classifier (
  input  wire logic           clock,
  input  wire logic           reset,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic                pready,
  output logic [31:0]         prdata,
  output logic                pslverr,
  input  wire mtc_pkg::mtc_tlp_t tlpIn,
  output mtc_pkg::mtc_bus_t   busOut,
  output mtc_pkg::mtc_err_t   errOut,
  output logic                staPrimary,
  output logic                staSecondary
);
  import mtc_pkg::*;

  // One register set decides for every function of the partition
  mtc_state_t st_r;
  mtc_state_t st_nxt;
  logic       pready_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [2:0] groupBits(input logic [5:0] enabled_group_count);
    logic [6:0] count;
    logic [2:0] bits;
    count = {1'b0, enabled_group_count} + 7'h01;
    bits  = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (count > (7'h01 << i)) begin
        bits = 3'(i + 1);
      end
    end
    return bits;
  endfunction : groupBits

  function automatic logic [31:0] clearOnes(input logic [31:0] cur, input logic [31:0] w);
    return cur & ~w;
  endfunction : clearOnes

  ////////////////////////////////////////////////////////////////////////////////
  // Classification

  logic [63:0] base;
  logic [63:0] lowMask;
  logic [63:0] gidMask;
  logic [63:0] gidWide;
  logic [5:0]  region_index_position;
  logic [5:0]  gid;
  logic        eligible;
  logic        baseHit;
  logic        inRange;
  logic        isMc;
  logic        acsReject;
  logic        blockedNow;

  always_comb begin
    region_index_position = st_r.baseLow[5:0];
    base     = {st_r.baseHigh, st_r.baseLow[31:BASE_LOW_LSB], 12'h000};
    lowMask  = (64'h1 << region_index_position) - 64'h1;
    gidMask  = (64'h1 << groupBits(st_r.enabled_group_count)) - 64'h1;
    // Base bits under these masks are assumed zero; software keeps them so
    baseHit  = (tlpIn.addr & ~(lowMask | (gidMask << region_index_position))) == base;
    gidWide  = (tlpIn.addr >> region_index_position) & gidMask;
    gid      = gidWide[5:0];
    inRange  = gid <= st_r.enabled_group_count;
    // Headers with errors go through the usual error path, never multicast
    eligible = tlpIn.valid & (tlpIn.postedWrite | tlpIn.addrMessage)
             & st_r.mcOn & ~tlpIn.headerError;
    // Address match alone qualifies; no membership test of the sender
    isMc       = eligible & baseHit & inRange;
    acsReject  = isMc & tlpIn.acsSourceFail;
    blockedNow = isMc & ~tlpIn.acsSourceFail
               & (st_r.blockAll[gid]
                  | (st_r.blockUt[gid] & (tlpIn.addrType == AT_UNTRANSLATED)));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic        wrEn;
  logic        rdEn;
  logic        mapped;
  logic [31:0] rdData;

  always_comb begin
    st_nxt = st_r;
    wrEn   = psel & penable & pwrite;
    rdEn   = psel & ~penable;
    mapped = 1'b1;
    rdData = 32'h0000_0000;
    unique case (paddr)
      OFF_CAPABILITY:  rdData = {26'h0, st_r.max_group_count};
      OFF_CONTROL:     rdData = {16'h0, st_r.mcOn, 9'h0, st_r.enabled_group_count};
      OFF_BASE_LOW:    rdData = st_r.baseLow;
      OFF_BASE_HIGH:   rdData = st_r.baseHigh;
      OFF_BLKALL_LOW:  rdData = st_r.blockAll[31:0];
      OFF_BLKALL_HIGH: rdData = st_r.blockAll[63:32];
      OFF_BLKUT_LOW:   rdData = st_r.blockUt[31:0];
      OFF_BLKUT_HIGH:  rdData = st_r.blockUt[63:32];
      OFF_STATUS:      rdData = {30'h0, st_r.staSecondary, st_r.staPrimary};
      OFF_PORT_CFG:    rdData = {31'h0, st_r.upstream};
      default:         mapped = 1'b0;
    endcase

    // Read data and error are set in setup so the access phase has no wait
    if (rdEn) begin
      st_nxt.prdata  = pwrite ? 32'h0000_0000 : rdData;
      st_nxt.pslverr = ~mapped;
    end

    if (wrEn && mapped) begin
      unique case (paddr)
        // Writable so initial configuration can advertise up to 64 groups
        OFF_CAPABILITY:  st_nxt.max_group_count = pwdata[5:0];
        OFF_CONTROL: begin
          st_nxt.enabled_group_count = pwdata[5:0];
          st_nxt.mcOn     = pwdata[POS_MC_ON];
        end
        OFF_BASE_LOW:    st_nxt.baseLow           = pwdata;
        OFF_BASE_HIGH:   st_nxt.baseHigh          = pwdata;
        OFF_BLKALL_LOW:  st_nxt.blockAll[31:0]    = pwdata;
        OFF_BLKALL_HIGH: st_nxt.blockAll[63:32]   = pwdata;
        OFF_BLKUT_LOW:   st_nxt.blockUt[31:0]     = pwdata;
        OFF_BLKUT_HIGH:  st_nxt.blockUt[63:32]    = pwdata;
        OFF_STATUS: begin
          {st_nxt.staSecondary, st_nxt.staPrimary} =
            2'(clearOnes({30'h0, st_r.staSecondary, st_r.staPrimary}, pwdata));
        end
        OFF_PORT_CFG:    st_nxt.upstream = pwdata[POS_UPSTREAM];
        default: ;
      endcase
    end

    // Hardware set beats a same-cycle software clear
    if (blockedNow) begin
      if (st_r.upstream) begin
        st_nxt.staPrimary = 1'b1;
      end else begin
        st_nxt.staSecondary = 1'b1;
      end
    end

    // One result per packet, same order as arrival, no reordering stage
    st_nxt.busOut.valid       = tlpIn.valid & ~blockedNow & ~acsReject;
    st_nxt.busOut.multicast   = isMc & ~blockedNow & ~acsReject;
    st_nxt.busOut.headerError = tlpIn.headerError;
    st_nxt.busOut.groupId     = isMc ? gid : 6'h00;
    st_nxt.busOut.partition   = tlpIn.partition;
    st_nxt.busOut.addr        = tlpIn.addr;

    st_nxt.errOut.mcBlocked    = blockedNow;
    st_nxt.errOut.creditReturn = blockedNow | acsReject;
    st_nxt.errOut.acsViolation = acsReject;
    st_nxt.errOut.loggedAddr   = (blockedNow | acsReject) ? tlpIn.addr
                                                          : st_r.errOut.loggedAddr;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r          <= '0;
      st_r.max_group_count <= RST_MAX_GROUP;
      pready_r      <= 1'b1;
    end else begin
      st_r     <= st_nxt;
      pready_r <= 1'b1;
    end
  end

  assign pready       = pready_r;
  assign prdata       = st_r.prdata;
  assign pslverr      = st_r.pslverr;
  assign busOut       = st_r.busOut;
  assign errOut       = st_r.errOut;
  assign staPrimary   = st_r.staPrimary;
  assign staSecondary = st_r.staSecondary;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_off_no_multicast: assert property (
    @(posedge clock) disable iff (reset)
    !st_r.mcOn |=> !st_r.busOut.multicast)
    else $error("multicast flagged while multicast is off");

  chk_nonposted_unicast: assert property (
    @(posedge clock) disable iff (reset)
    (tlpIn.valid && !tlpIn.postedWrite && !tlpIn.addrMessage)
      |=> (st_r.busOut.valid && !st_r.busOut.multicast))
    else $error("ineligible packet classified as multicast");

  chk_blocked_dropped: assert property (
    @(posedge clock) disable iff (reset)
    st_r.errOut.mcBlocked |-> (!st_r.busOut.valid && st_r.errOut.creditReturn))
    else $error("blocked packet forwarded or credits kept");

  chk_abort_flag_set: assert property (
    @(posedge clock) disable iff (reset)
    (blockedNow && st_r.upstream) |=> st_r.staPrimary && st_r.errOut.mcBlocked)
    else $error("upstream block did not set primary target abort");

  chk_abort_flag_sec: assert property (
    @(posedge clock) disable iff (reset)
    (blockedNow && !st_r.upstream) |=> st_r.staSecondary)
    else $error("downstream block did not set secondary target abort");

  chk_partition_kept: assert property (
    @(posedge clock) disable iff (reset)
    st_r.busOut.valid |-> (st_r.busOut.partition == $past(tlpIn.partition)))
    else $error("packet left its partition");

  chk_group_range: assert property (
    @(posedge clock) disable iff (reset)
    st_r.busOut.multicast |-> (st_r.busOut.groupId <= $past(st_r.enabled_group_count)))
    else $error("group id above enabled count");

  chk_one_per_packet: assert property (
    @(posedge clock) disable iff (reset)
    (st_r.busOut.valid || st_r.errOut.creditReturn) |-> $past(tlpIn.valid))
    else $error("output without an input packet");

  chk_block_all: assert property (
    @(posedge clock) disable iff (reset)
    (isMc && !tlpIn.acsSourceFail && st_r.blockAll[gid]) |=> !st_r.busOut.valid)
    else $error("block-all group not blocked");

  chk_all_groups: assert property (
    @(posedge clock) disable iff (reset)
    (eligible && baseHit && st_r.enabled_group_count == 6'(GROUP_MAX - 1))
      |=> (st_r.busOut.multicast || st_r.errOut.creditReturn))
    else $error("hit in a full set of groups not taken");

  chk_max_group_reset: assert property (
    @(posedge clock) $fell(reset) |-> (st_r.max_group_count == RST_MAX_GROUP))
    else $error("max group field not at reset value");

  chk_unicast_passes: assert property (
    @(posedge clock) disable iff (reset)
    (tlpIn.valid && !isMc) |=> (st_r.busOut.valid && !st_r.busOut.multicast
      && st_r.busOut.addr == $past(tlpIn.addr)))
    else $error("non-multicast packet not routed on");

  chk_header_error: assert property (
    @(posedge clock) disable iff (reset)
    (tlpIn.valid && tlpIn.headerError) |=> (st_r.busOut.valid
      && st_r.busOut.headerError && !st_r.busOut.multicast))
    else $error("errored header not passed to normal handling");

  chk_base_mismatch: assert property (
    @(posedge clock) disable iff (reset)
    (tlpIn.valid && !baseHit) |=> !st_r.busOut.multicast)
    else $error("base mismatch classified as multicast");

  chk_region_contig: assert property (
    @(posedge clock) disable iff (reset)
    (tlpIn.valid && gid > st_r.enabled_group_count) |=> !st_r.busOut.multicast)
    else $error("group above enabled count has a region");

  chk_region_size: assert property (
    @(posedge clock) disable iff (reset)
    (tlpIn.valid && baseHit) |-> (((tlpIn.addr - base) >> region_index_position) == {58'h0, gid}))
    else $error("group region size not two to index position");

  chk_acs_unicast: assert property (
    @(posedge clock) disable iff (reset)
    (tlpIn.valid && !isMc && tlpIn.acsSourceFail)
      |=> (st_r.busOut.valid && !st_r.errOut.acsViolation))
    else $error("source check applied to a unicast packet");

  chk_acs_reject: assert property (
    @(posedge clock) disable iff (reset)
    (isMc && tlpIn.acsSourceFail) |=> (st_r.errOut.acsViolation
      && st_r.errOut.creditReturn && !st_r.busOut.valid))
    else $error("source validation failure not rejected");

  chk_block_untrans: assert property (
    @(posedge clock) disable iff (reset)
    (isMc && !tlpIn.acsSourceFail && st_r.blockUt[gid] && tlpIn.addrType == AT_UNTRANSLATED)
      |=> (st_r.errOut.mcBlocked && !st_r.busOut.valid))
    else $error("untranslated packet not blocked");

  chk_translated_pass: assert property (
    @(posedge clock) disable iff (reset)
    (isMc && !tlpIn.acsSourceFail && !st_r.blockAll[gid] && tlpIn.addrType != AT_UNTRANSLATED)
      |=> (st_r.busOut.valid && st_r.busOut.multicast))
    else $error("translated packet blocked without block-all");

  chk_header_logged: assert property (
    @(posedge clock) disable iff (reset)
    st_r.errOut.mcBlocked |-> (st_r.errOut.loggedAddr == $past(tlpIn.addr)))
    else $error("blocked header not logged");

  chk_clean_forward: assert property (
    @(posedge clock) disable iff (reset)
    st_r.busOut.multicast |-> (st_r.busOut.valid && !st_r.busOut.headerError
      && !st_r.errOut.creditReturn))
    else $error("unclean multicast packet passed on");

  chk_eligible_only: assert property (
    @(posedge clock) disable iff (reset)
    st_r.busOut.multicast |-> ($past(tlpIn.postedWrite) || $past(tlpIn.addrMessage)))
    else $error("multicast from an ineligible packet type");

  chk_abort_clear: assert property (
    @(posedge clock) disable iff (reset)
    (psel && penable && pwrite && paddr == OFF_STATUS && pwdata[POS_STA_PRI] && !blockedNow)
      |=> !st_r.staPrimary)
    else $error("primary target abort flag not cleared");

  chk_one_outcome: assert property (
    @(posedge clock) disable iff (reset)
    tlpIn.valid |=> (st_r.busOut.valid != st_r.errOut.creditReturn))
    else $error("packet without exactly one outcome");

  chk_off_no_block: assert property (
    @(posedge clock) disable iff (reset)
    !st_r.mcOn |=> !(st_r.errOut.mcBlocked || st_r.errOut.acsViolation))
    else $error("multicast filter applied while multicast is off");

  chk_apb_zero_wait: assert property (
    @(posedge clock) disable iff (reset)
    (psel && penable) |-> pready)
    else $error("access phase without ready");

  chk_unmapped_error: assert property (
    @(posedge clock) disable iff (reset)
    (psel && !penable && !mapped) |=> st_r.pslverr)
    else $error("unmapped access without slave error");

  chk_blkall_high: assert property (
    @(posedge clock) disable iff (reset)
    (psel && penable && pwrite && paddr == OFF_BLKALL_HIGH)
      |=> (st_r.blockAll[63:32] == $past(pwdata)))
    else $error("upper block-all half not written");

endmodule : mtc_classifier

// File: bench/mtc_link_model.sv
// Link partner model: drives one packet header per send call, two per send_pair call, into the classifier ingress.
// Assumes the bench calls send from its clocked sequence, one packet per call.
`timescale 1ns/10ps

module mtc_link_model (
  input  wire logic         clock,
  input  wire logic         reset,
  output mtc_pkg::mtc_tlp_t tlpIn
);
  import mtc_pkg::*;

  initial tlpIn = '0;

  // Header stands one cycle; after it the fields show the inverse, never stale values
  task automatic send(input mtc_tlp_t p);
    mtc_tlp_t q;
    q = ~p;
    q.valid = 1'b0;
    while (reset) @(posedge clock);
    @(posedge clock);
    tlpIn <= p;
    @(posedge clock);
    tlpIn <= q;
  endtask : send

  // Two headers on consecutive edges, to see that order is kept
  task automatic send_pair(input mtc_tlp_t a, input mtc_tlp_t b);
    mtc_tlp_t q;
    q = ~b;
    q.valid = 1'b0;
    while (reset) @(posedge clock);
    @(posedge clock);
    tlpIn <= a;
    @(posedge clock);
    tlpIn <= b;
    @(posedge clock);
    tlpIn <= q;
  endtask : send_pair
endmodule : mtc_link_model

// File: bench/mtc_classifier_test.sv
// Self-checking bench: programs the classifier over APB and sends headers via the link model.
// Assumes zero-wait APB slave and one-cycle packet latency as handed over.
`timescale 1ns/10ps

module mtc_classifier_test;
  import mtc_pkg::*;
  localparam logic [63:0] BASE = 64'h0000_0001_0000_0000;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        staPrimary;
  logic        staSecondary;
  mtc_tlp_t    tlpIn;
  mtc_bus_t    busOut;
  mtc_err_t    errOut;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;

  always #25 clock = ~clock;

  mtc_link_model link (.clock(clock), .reset(reset), .tlpIn(tlpIn));
  mtc_classifier dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tlpIn(tlpIn), .busOut(busOut), .errOut(errOut),
    .staPrimary(staPrimary), .staSecondary(staSecondary));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // A hung handshake would otherwise stall the run forever
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk({err, rd}, {expErr, exp}, "register read");
  endtask : rdchk

  // kind = {postedWrite, addrMessage}; exp = {busValid, multicast, blocked, acs, credit}
  task automatic pkt(input logic [1:0] kind, input logic acs, input logic [1:0] at,
                     input int g, input logic [4:0] exp);
    mtc_tlp_t p;
    p = '0;
    p.valid = 1'b1;
    {p.postedWrite, p.addrMessage} = kind;
    p.acsSourceFail = acs;
    p.addrType = at;
    p.partition = 4'h3;
    p.addr = BASE + (64'(g) << 12) + 64'h40;
    link.send(p);
    #1;
    chk({busOut.valid, busOut.multicast, errOut.mcBlocked, errOut.acsViolation,
         errOut.creditReturn}, exp, "packet outcome");
    if (exp[4]) chk(busOut.addr, p.addr, "forwarded address");
    if (exp[3]) chk({busOut.groupId, busOut.partition}, {g[5:0], 4'h3}, "group id");
    if (exp[2]) chk(errOut.loggedAddr, p.addr, "logged header");
  endtask : pkt

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rdchk(OFF_CAPABILITY, 32'h1F, 1'b0);
    rdchk(OFF_STATUS, 32'h0, 1'b0);
    rdchk(8'h30, 32'h0, 1'b1);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_decode();
    // Traffic is idle while routing fields change
    wr(OFF_BASE_HIGH, 32'h1);
    wr(OFF_BASE_LOW, 32'hC);
    wr(OFF_CONTROL, 32'h8004);
    rdchk(OFF_CONTROL, 32'h8004, 1'b0);
    pkt(2'b10, 1'b0, 2'h1, 0, 5'b11000);
    pkt(2'b10, 1'b0, 2'h1, 2, 5'b11000);
    pkt(2'b10, 1'b0, 2'h1, 4, 5'b11000);
    pkt(2'b10, 1'b0, 2'h1, 5, 5'b10000);
    pkt(2'b10, 1'b0, 2'h1, 8, 5'b10000);
    pkt(2'b01, 1'b0, 2'h1, 3, 5'b11000);
    pkt(2'b00, 1'b0, 2'h1, 3, 5'b10000);
    $display("test_decode done");
  endtask : test_decode

  task automatic test_block();
    wr(OFF_BLKALL_LOW, 32'h10);
    pkt(2'b10, 1'b0, 2'h1, 4, 5'b00101);
    chk({staPrimary, staSecondary}, 2'b01, "downstream abort flag");
    wr(OFF_PORT_CFG, 32'h1);
    wr(OFF_STATUS, 32'h3);
    wr(OFF_BLKUT_LOW, 32'h2);
    pkt(2'b10, 1'b0, 2'h1, 1, 5'b11000);
    pkt(2'b10, 1'b0, AT_UNTRANSLATED, 1, 5'b00101);
    chk({staPrimary, staSecondary}, 2'b10, "upstream abort flag");
    pkt(2'b10, 1'b1, 2'h1, 2, 5'b00011);
    pkt(2'b00, 1'b1, 2'h1, 2, 5'b10000);
    $display("test_block done");
  endtask : test_block

  task automatic test_order();
    mtc_tlp_t a;
    mtc_tlp_t b;
    a = '0;
    a.valid = 1'b1;
    a.postedWrite = 1'b1;
    a.addrType = 2'h1;
    a.addr = BASE + 64'h2000;
    b = a;
    a.headerError = 1'b1;
    b.addr = BASE + 64'h3000;
    fork
      link.send_pair(a, b);
      begin
        repeat (2) @(posedge clock);
        #1;
        chk({busOut.valid, busOut.multicast, busOut.headerError}, 3'b101, "bad hdr");
        @(posedge clock);
        #1;
        chk({busOut.valid, busOut.multicast, busOut.groupId}, {2'b11, 6'h03}, "seq");
        chk(busOut.addr, b.addr, "order address");
      end
    join
    $display("test_order done");
  endtask : test_order

  task automatic test_groups();
    wr(OFF_CAPABILITY, 32'h3F);
    rdchk(OFF_CAPABILITY, 32'h3F, 1'b0);
    wr(OFF_CONTROL, 32'h803F);
    wr(OFF_BLKALL_HIGH, 32'h100);
    rdchk(OFF_BLKALL_HIGH, 32'h100, 1'b0);
    pkt(2'b10, 1'b0, 2'h1, 63, 5'b11000);
    pkt(2'b10, 1'b0, 2'h1, 40, 5'b00101);
    $display("test_groups done");
  endtask : test_groups

  task automatic test_disable();
    wr(OFF_CONTROL, 32'h0004);
    pkt(2'b10, 1'b0, 2'h1, 2, 5'b10000);
    $display("test_disable done");
  endtask : test_disable

  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    test_reset();
    test_decode();
    test_order();
    test_block();
    test_groups();
    test_disable();
    end_sim();
  end
endmodule : mtc_classifier_test
